// file: aci_pkg.sv
package aci_pkg;
    // ****************************************
    // synchronised pin positions
    // ****************************************
    localparam int PIN_W = 11;
    localparam int PIN_CMD_N = 0;
    localparam int PIN_ADDR_LATCH = 1;
    localparam int PIN_MEM_IO = 2;
    localparam int PIN_WRITE = 3;
    localparam int PIN_REFRESH_N = 4;
    localparam int PIN_CARD_SEL_N = 5;
    localparam int PIN_WIDE_N = 6;
    localparam int PIN_ERROR_N = 7;
    localparam int PIN_SLOW_N = 8;
    localparam int PIN_RDY_STB = 9;
    localparam int PIN_CH_RESET = 10;
    // idle pin levels, so no false edge or stray reset follows rst_i
    localparam logic [10:0] PIN_RESET = 11'h1F1;
    // ****************************************
    // extension state
    // ****************************************
    typedef enum logic [2:0] {
        EXT_IDLE = 3'b001,
        EXT_HOLD = 3'b010,
        EXT_DONE = 3'b100
    } aci_ext_t;
endpackage

// file: aci_pins_if.sv
`timescale 1ns/10ps
interface aci_pins_if;
    logic [aci_pkg::PIN_W-1:0] synced;
    modport src (output synced);
    modport dst (input synced);
endinterface

// file: aci_pin_sync.sv
`timescale 1ns/10ps
module aci_pin_sync (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [aci_pkg::PIN_W-1:0] pins_i,
    aci_pins_if.src sync_o
);
    logic [aci_pkg::PIN_W-1:0] meta;
    logic [aci_pkg::PIN_W-1:0] stable;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= aci_pkg::PIN_RESET;
            stable <= aci_pkg::PIN_RESET;
        end else begin
            meta <= pins_i;
            stable <= meta;
        end
    end

    assign sync_o.synced = stable;
endmodule

// file: aci_top.sv
`timescale 1ns/10ps
module aci_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic bus_cmd_n_i,
    input wire logic bus_addr_latch_i,
    input wire logic bus_mem_io_i,
    input wire logic bus_write_i,
    input wire logic bus_refresh_n_i,
    input wire logic channel_reset_i,
    input wire logic card_select_n_i,
    input wire logic wide_data_path_n_i,
    input wire logic adapter_error_n_i,
    input wire logic adapter_slow_n_i,
    input wire logic ready_strobe_i,
    input wire logic sync_ext_mode_i,
    input wire logic card_disable_wr_i,
    input wire logic error_flag_set_i,
    output logic mem_read_strobe_n_o,
    output logic mem_write_strobe_n_o,
    output logic io_read_strobe_n_o,
    output logic io_write_strobe_n_o,
    output logic wide_path_o,
    output logic channel_check_n_o,
    output logic channel_ready_o,
    output logic error_flag_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    aci_pins_if pins ();

    aci_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pins_i({channel_reset_i, ready_strobe_i, adapter_slow_n_i, adapter_error_n_i,
                 wide_data_path_n_i, card_select_n_i, bus_refresh_n_i, bus_write_i,
                 bus_mem_io_i, bus_addr_latch_i, bus_cmd_n_i}),
        .sync_o(pins.src)
    );

    logic cmd_act;
    logic addr_latch;
    logic is_mem;
    logic is_write;
    logic refresh;
    logic sel_pin;
    logic error_act;
    logic slow_act;
    logic rdy_stb;
    logic ch_reset;
    assign cmd_act = !pins.synced[aci_pkg::PIN_CMD_N];
    assign addr_latch = pins.synced[aci_pkg::PIN_ADDR_LATCH];
    assign is_mem = pins.synced[aci_pkg::PIN_MEM_IO];
    assign is_write = pins.synced[aci_pkg::PIN_WRITE];
    assign refresh = !pins.synced[aci_pkg::PIN_REFRESH_N];
    assign sel_pin = !pins.synced[aci_pkg::PIN_CARD_SEL_N];
    assign error_act = !pins.synced[aci_pkg::PIN_ERROR_N];
    assign slow_act = !pins.synced[aci_pkg::PIN_SLOW_N];
    assign rdy_stb = pins.synced[aci_pkg::PIN_RDY_STB];
    assign ch_reset = pins.synced[aci_pkg::PIN_CH_RESET];

    // ****************************************
    // edge history
    // ****************************************
    logic cmd_d;
    logic rdy_stb_d;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_d <= 1'b0;
            rdy_stb_d <= 1'b0;
        end else begin
            cmd_d <= cmd_act;
            rdy_stb_d <= rdy_stb;
        end
    end

    logic cmd_rise;
    logic stb_rise;
    assign cmd_rise = cmd_act && !cmd_d;
    assign stb_rise = rdy_stb && !rdy_stb_d;

    // ****************************************
    // card select and width latch
    // ****************************************
    // transparent while address valid, held through the command
    logic sel_lat;
    logic wide_lat;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sel_lat <= 1'b0;
            wide_lat <= 1'b0;
        end else if (ch_reset) begin
            sel_lat <= 1'b0;
            wide_lat <= 1'b0;
        end else if (addr_latch) begin
            sel_lat <= sel_pin;
            wide_lat <= !pins.synced[aci_pkg::PIN_WIDE_N];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wide_path_o <= 1'b0;
        end else begin
            wide_path_o <= wide_lat;
        end
    end

    // ****************************************
    // adapter strobes
    // ****************************************
    logic sel_cmd;
    logic next_mem_rd_n;
    logic next_mem_wr_n;
    logic next_io_rd_n;
    logic next_io_wr_n;
    assign sel_cmd = cmd_act && sel_lat && !ch_reset;
    // refresh reaches every card, so it bypasses the select
    assign next_mem_rd_n = !((sel_cmd && is_mem && !is_write)
                             || (cmd_act && refresh && !ch_reset));
    assign next_mem_wr_n = !(sel_cmd && is_mem && is_write && !refresh);
    assign next_io_rd_n = !(sel_cmd && !is_mem && !is_write && !refresh);
    assign next_io_wr_n = !(sel_cmd && !is_mem && is_write && !refresh);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mem_read_strobe_n_o <= 1'b1;
            mem_write_strobe_n_o <= 1'b1;
            io_read_strobe_n_o <= 1'b1;
            io_write_strobe_n_o <= 1'b1;
        end else begin
            mem_read_strobe_n_o <= next_mem_rd_n;
            mem_write_strobe_n_o <= next_mem_wr_n;
            io_read_strobe_n_o <= next_io_rd_n;
            io_write_strobe_n_o <= next_io_wr_n;
        end
    end

    // ****************************************
    // channel check and error flag
    // ****************************************
    // muted by disable or reset until the adapter drops its error line
    logic chk_mute;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            chk_mute <= 1'b0;
        end else if (card_disable_wr_i || ch_reset) begin
            chk_mute <= 1'b1;
        end else if (!error_act) begin
            chk_mute <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            channel_check_n_o <= 1'b1;
        end else begin
            channel_check_n_o <= !(error_act && !chk_mute && !card_disable_wr_i
                                   && !ch_reset);
        end
    end

    // the error wins over a simultaneous software set
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            error_flag_o <= 1'b1;
        end else if (error_act) begin
            error_flag_o <= 1'b0;
        end else if (error_flag_set_i) begin
            error_flag_o <= 1'b1;
        end
    end

    // ****************************************
    // cycle extension
    // ****************************************
    aci_pkg::aci_ext_t ext_state;
    logic ext_end;
    assign ext_end = sync_ext_mode_i ? cmd_rise : stb_rise;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ext_state <= aci_pkg::EXT_IDLE;
        end else if (ch_reset) begin
            ext_state <= aci_pkg::EXT_IDLE;
        end else begin
            case (ext_state)
                aci_pkg::EXT_IDLE: begin
                    if (slow_act && !ext_end) begin
                        ext_state <= aci_pkg::EXT_HOLD;
                    end
                end
                aci_pkg::EXT_HOLD: begin
                    if (ext_end || !slow_act) begin
                        ext_state <= aci_pkg::EXT_DONE;
                    end
                end
                aci_pkg::EXT_DONE: begin
                    // no re-arm until slow request drops
                    if (!slow_act) begin
                        ext_state <= aci_pkg::EXT_IDLE;
                    end
                end
                default: begin
                    ext_state <= aci_pkg::EXT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            channel_ready_o <= 1'b1;
        end else begin
            channel_ready_o <= (ext_state != aci_pkg::EXT_HOLD);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    mem_read_strobe_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cmd_act && refresh && !ch_reset) |=> !mem_read_strobe_n_o)
        else $error("memory read strobe missing");
    mem_write_strobe_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sel_cmd && is_mem && is_write && !refresh) |=> !mem_write_strobe_n_o)
        else $error("memory write strobe missing");
    io_read_strobe_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sel_cmd && !is_mem && !is_write && !refresh) |=> !io_read_strobe_n_o)
        else $error("io read strobe missing");
    io_write_strobe_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (sel_cmd && !is_mem && is_write && !refresh) |=> !io_write_strobe_n_o)
        else $error("io write strobe missing");
    strobe_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!sel_lat || !cmd_act) |=> (mem_write_strobe_n_o && io_read_strobe_n_o
                                    && io_write_strobe_n_o))
        else $error("strobe active without selected command");
    check_assert_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (error_act && !chk_mute && !card_disable_wr_i && !ch_reset) |=> !channel_check_n_o)
        else $error("channel check not asserted");
    check_drop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (card_disable_wr_i || ch_reset) |=> channel_check_n_o [*2])
        else $error("channel check not dropped");
    error_sticky_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (error_act ##1 !error_act && !error_flag_set_i) |=> !error_flag_o)
        else $error("error flag not sticky");
    flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (error_flag_set_i && !error_act) |=> error_flag_o)
        else $error("error flag not set by write");
    ready_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ext_state == aci_pkg::EXT_IDLE && slow_act && !ext_end && !ch_reset)
        |=> ##1 !channel_ready_o)
        else $error("channel ready not pulled low");
    ready_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ext_state == aci_pkg::EXT_HOLD && ext_end) |=> ##1 channel_ready_o)
        else $error("channel ready not released");

    extend_async_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_state == aci_pkg::EXT_HOLD && stb_rise && !sync_ext_mode_i);
    extend_sync_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_state == aci_pkg::EXT_HOLD && cmd_rise && sync_ext_mode_i);
    error_clear_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        !error_flag_o && error_flag_set_i && !error_act);
    io_write_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        !io_write_strobe_n_o);
endmodule

// file: aci_adapter_model.sv
`timescale 1ns/10ps
module aci_adapter_model (
    input wire logic clk_sys_i,
    input wire logic sel_i,
    input wire logic wide16_i,
    input wire logic err_i,
    input wire logic slow_i,
    input wire logic [5:0] rdy_dly_i,
    output logic card_select_n_o,
    output logic wide_data_path_n_o,
    output logic adapter_error_n_o,
    output logic adapter_slow_n_o,
    output logic ready_strobe_o
);
    // ****************************************
    // unlatched address decodes
    // ****************************************
    logic [5:0] wait_cnt = 6'h00;
    assign card_select_n_o = ~sel_i;
    assign wide_data_path_n_o = ~wide16_i;
    assign adapter_error_n_o = ~err_i;
    assign adapter_slow_n_o = ~slow_i;
    // slow responder: strobe rises only after the programmed wait
    always_ff @(posedge clk_sys_i) begin
        if (!slow_i) begin
            wait_cnt <= 6'h00;
        end else if (wait_cnt != 6'h3f) begin
            wait_cnt <= wait_cnt + 6'h01;
        end
    end
    assign ready_strobe_o = slow_i && (wait_cnt >= rdy_dly_i);
endmodule

// file: aci_tb_top.sv
`timescale 1ns/10ps
module aci_tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_n = 1'b1, alatch = 1'b0, mem_io = 1'b0, wr = 1'b0, rf_n = 1'b1;
    logic ch_rst = 1'b0, ext_mode = 1'b0, dis_wr = 1'b0, flag_set = 1'b0;
    logic a_sel = 1'b0, a_wide = 1'b0, a_err = 1'b0, a_slow = 1'b0;
    logic [5:0] a_dly = 6'h08;
    logic sel_n, wide_n, err_n, slow_n, rdy_stb;
    logic [3:0] strb;
    logic wide_path, check_n, ready, flag;
    int fail_count = 0;
    int cmp_count = 0;

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    aci_adapter_model adapter (.clk_sys_i(clk_sys_i), .sel_i(a_sel), .wide16_i(a_wide),
        .err_i(a_err), .slow_i(a_slow), .rdy_dly_i(a_dly), .card_select_n_o(sel_n),
        .wide_data_path_n_o(wide_n), .adapter_error_n_o(err_n),
        .adapter_slow_n_o(slow_n), .ready_strobe_o(rdy_stb));

    aci_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_cmd_n_i(cmd_n),
        .bus_addr_latch_i(alatch), .bus_mem_io_i(mem_io), .bus_write_i(wr),
        .bus_refresh_n_i(rf_n), .channel_reset_i(ch_rst), .card_select_n_i(sel_n),
        .wide_data_path_n_i(wide_n), .adapter_error_n_i(err_n),
        .adapter_slow_n_i(slow_n), .ready_strobe_i(rdy_stb), .sync_ext_mode_i(ext_mode),
        .card_disable_wr_i(dis_wr), .error_flag_set_i(flag_set),
        .mem_read_strobe_n_o(strb[3]), .mem_write_strobe_n_o(strb[2]),
        .io_read_strobe_n_o(strb[1]), .io_write_strobe_n_o(strb[0]),
        .wide_path_o(wide_path), .channel_check_n_o(check_n),
        .channel_ready_o(ready), .error_flag_o(flag));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // select is dropped as the command starts to prove the strobes run off the latch
    task automatic bus_cycle(input logic m, input logic w, input logic s, input logic r,
                             input logic wd, input logic [3:0] exp);
        mem_io = m;
        wr = w;
        rf_n = r;
        a_sel = s;
        a_wide = wd;
        alatch = 1'b1;
        cyc(4);
        alatch = 1'b0;
        cyc(1);
        a_sel = 1'b0;
        cmd_n = 1'b0;
        cyc(4);
        chk(strb, exp);
        if (s) chk({3'h0, wide_path}, {3'h0, wd});
        cmd_n = 1'b1;
        rf_n = 1'b1;
        cyc(4);
        chk(strb, 4'hf);
        $display("bus cycle m=%0d w=%0d s=%0d r=%0d done", m, w, s, r);
    endtask

    task automatic error_path();
        a_err = 1'b1;
        cyc(4);
        chk({2'h0, check_n, flag}, 4'h0);
        dis_wr = 1'b1;
        cyc(1);
        dis_wr = 1'b0;
        cyc(2);
        chk({3'h0, check_n}, 4'h1);
        a_err = 1'b0;
        cyc(5);
        chk({3'h0, flag}, 4'h0);
        flag_set = 1'b1;
        cyc(1);
        flag_set = 1'b0;
        cyc(1);
        chk({3'h0, flag}, 4'h1);
        a_err = 1'b1;
        cyc(4);
        chk({3'h0, check_n}, 4'h0);
        ch_rst = 1'b1;
        cyc(4);
        chk({3'h0, check_n}, 4'h1);
        ch_rst = 1'b0;
        a_err = 1'b0;
        cyc(5);
        $display("error path done");
    endtask

    task automatic extension(input logic mode);
        ext_mode = mode;
        a_dly = mode ? 6'h3f : 6'h08;
        a_slow = 1'b1;
        cyc(5);
        chk({3'h0, ready}, 4'h0);
        if (mode) cmd_n = 1'b0;
        cyc(9);
        chk({3'h0, ready}, 4'h1);
        cyc(4);
        chk({3'h0, ready}, 4'h1);
        a_slow = 1'b0;
        cmd_n = 1'b1;
        cyc(5);
        $display("extension mode %0d done", mode);
    endtask

    initial begin
        // the scenarios need under 200 cycles; ten times that means a hang
        repeat (2000) @(posedge clk_sys_i);
        fail_count++;
        wrap_up();
    end

    initial begin
        cyc(3);
        rst_i = 1'b0;
        cyc(2);
        bus_cycle(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h7);
        bus_cycle(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'hb);
        bus_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hd);
        bus_cycle(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'he);
        bus_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h7);
        bus_cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hf);
        error_path();
        extension(1'b0);
        extension(1'b1);
        wrap_up();
    end
endmodule
